// >>> logic/parallel_port_strap_mux.sv
/*
  Parallel port pin multiplexer with reset straps: strap capture,
  boot code decode, per-pin routing between the memory interface,
  the wide host port and parallel general I/O, and status outputs.
  Assumes pin inputs are synchronous to SYS_CLK, straps steady from
  reset release until capture, and pad wires resolved outside from
  the output enables (low enable means driven).
*/
// Function
// - all pin muxes set at reset from straps; register reports the choice.
// - parallel mode comes only from the sampled parallel mux strap.
// - strap low: memory interface off, host on A[17:2], D[15:0].
// - host mode connects 16 address and 16 data signals; all control pins are gpio.
// - host mode: A[21:18] are gpio[3:0], D[31:16] are gpio[19:4].
// - host mode: C0..C15 are gpio 20..35 ascending.
// - strap low clears the mode bit to 0.
// - strap high: memory interface owns A[21:2] and D[31:0].
// - memory mode control pins: strobes, ready, CE, BE, CKE, SOE, hold.
// - strap high sets the mode bit to 1.
// - multiplexed host uses the eight host byte pins, not this port.
// - boot straps captured on first clock edge after synchronised reset release.
// - boot straps share gpio 2..0 and act only at reset.
// - boot code decodes to one of eight boot sources.
// - bus selection register bit 0 holds mode, reset from strap.
`timescale 1ns/100ps
module parallel_port_strap_mux
  import pmux_pkg::*;
(
  input  wire logic        SYS_CLK,          // 50 MHz system clock
  input  wire logic        RESET_N,          // Async reset, active low
  input  wire logic        PMUX_STRAP,       // Parallel mux strap pin
  input  wire logic        SER2_STRAP,       // Serial 2 mux strap pin
  input  wire logic [2:0]  BOOT_STRAP,       // Boot straps on gpio[2:0]
  // Pads
  input  wire logic [19:0] A_IN,             // Address pins in A[21:2]
  output logic      [19:0] A_OUT,            // Address pins out
  output logic      [19:0] A_OE_N,           // Address enables, low drives
  input  wire logic [31:0] D_IN,             // Data pins in
  output logic      [31:0] D_OUT,            // Data pins out
  output logic      [31:0] D_OE_N,           // Data enables, low drives
  input  wire logic [15:0] C_IN,             // Control pins in
  output logic      [15:0] C_OUT,            // Control pins out
  output logic      [15:0] C_OE_N,           // Control enables, low drives
  // Memory interface side
  input  wire logic [19:0] MEM_ADDR,         // Memory address out
  input  wire logic [31:0] MEM_DATA_O,       // Memory write data
  input  wire logic        MEM_DATA_OE,      // Memory drives data, high
  output logic      [31:0] MEM_DATA_I,       // Memory read data
  input  wire logic [15:0] MEM_CTRL_O,       // Memory control outputs
  input  wire logic [15:0] MEM_CTRL_OE,      // Per-pin drive, high
  output logic      [15:0] MEM_CTRL_I,       // Memory control inputs
  output logic             MEM_ENABLE,       // Memory interface enabled
  // Host port side
  output logic      [15:0] HOST_ADDR,        // Host address lines
  input  wire logic [15:0] HOST_DATA_O,      // Host read data
  input  wire logic        HOST_DATA_OE,     // Host drives data, high
  output logic      [15:0] HOST_DATA_I,      // Host write data
  output logic             HOST_WIDE,        // 1 non-multiplexed host
  output logic             HOST_BYTE_PINS,   // 1 host on byte pins
  // General I/O side
  input  wire logic [35:0] GPIO_O,           // General I/O out values
  input  wire logic [35:0] GPIO_DIR,         // 1 drives pin
  output logic      [35:0] GPIO_I,           // General I/O pin levels
  output logic             GPIO_ENABLE,      // General I/O owns pins
  // Status
  output logic      [15:0] BUS_SEL_REG,      // Bus selection register
  output logic      [2:0]  BOOT_CODE,        // Latched boot code
  output logic      [2:0]  BOOT_SRC,         // Decoded boot source
  output logic             BOOT_DIRECT,      // Direct execution boot
  output logic             STRAP_DONE        // Straps captured
);

  ////////////////////////////////////////////////////////////////////
  // Reset synchroniser; first stage is read only by the second
  // Gives every flop the same release edge, whatever the raw timing
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wire rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////
  // Strap capture and boot decode
  strap_if st ();

  strap_latch u_latch (
    .clk        (SYS_CLK),
    .rst_n      (rst_n),
    .pmux_strap (PMUX_STRAP),
    .ser2_strap (SER2_STRAP),
    .boot_strap (BOOT_STRAP),
    .st         (st)
  );

  boot_src_t boot_src;
  logic      boot_direct;

  boot_decode u_dec (
    .code   (st.boot_code),
    .src    (boot_src),
    .direct (boot_direct),
    .wide32 ()
  );

  ////////////////////////////////////////////////////////////////////
  // Mode: pins stay undriven until the straps are in, then the mode
  // never changes until the next reset, no software path exists
  wire mem_mode  = st.done && st.pmux_mode;
  wire host_mode = st.done && !st.pmux_mode;

  ////////////////////////////////////////////////////////////////////
  // Memory mode pin drives
  wire [19:0] m_a_out = MEM_ADDR;
  wire [31:0] m_d_oe  = {DATA_W{MEM_DATA_OE}};
  // Control pins keep strobe, ready, CE, BE, CKE, SOE, hold order
  wire [15:0] m_c_oe  = MEM_CTRL_OE;

  ////////////////////////////////////////////////////////////////////
  // Host mode pin drives: host on low fields, gpio on the rest
  // Host address pins are inputs only, so their out values stay zero
  wire [19:0] h_a_out = {GPIO_O[GPIO_ADDR_LO +: 4], 16'h0000};
  wire [19:0] h_a_oe  = {GPIO_DIR[GPIO_ADDR_LO +: 4], 16'h0000};
  wire [31:0] h_d_out = {GPIO_O[GPIO_DATA_LO +: 16], HOST_DATA_O};
  wire [31:0] h_d_oe  = {GPIO_DIR[GPIO_DATA_LO +: 16],
                         {HDATA_W{HOST_DATA_OE}}};
  wire [15:0] h_c_out = GPIO_O[GPIO_CTRL_LO +: 16];
  wire [15:0] h_c_oe  = GPIO_DIR[GPIO_CTRL_LO +: 16];

  ////////////////////////////////////////////////////////////////////
  // Per-pin selection over all 68 pads, packed {C, D, A}. Until the
  // straps are in neither function may drive, so no pad is fought
  // while the mode is still unknown
  wire  [67:0] m_pin_out = {MEM_CTRL_O, MEM_DATA_O, m_a_out};
  wire  [67:0] m_pin_oe  = {m_c_oe, m_d_oe, {ADDR_W{1'b1}}};
  wire  [67:0] h_pin_out = {h_c_out, h_d_out, h_a_out};
  wire  [67:0] h_pin_oe  = {h_c_oe, h_d_oe, h_a_oe};
  logic [67:0] nxt_pin_out;
  logic [67:0] nxt_pin_oe;

  for (genvar i = 0; i < 68; i++) begin : g_pin
    assign nxt_pin_out[i] = mem_mode ? m_pin_out[i] : h_pin_out[i];
    assign nxt_pin_oe[i]  = mem_mode ? m_pin_oe[i]
                                     : (host_mode && h_pin_oe[i]);
  end

  // Group views of the selected pads
  wire [19:0] nxt_a_out = nxt_pin_out[19:0];
  wire [19:0] nxt_a_oe  = nxt_pin_oe[19:0];
  wire [31:0] nxt_d_out = nxt_pin_out[51:20];
  wire [31:0] nxt_d_oe  = nxt_pin_oe[51:20];
  wire [15:0] nxt_c_out = nxt_pin_out[67:52];
  wire [15:0] nxt_c_oe  = nxt_pin_oe[67:52];

  // Inbound routing, unselected functions see zero
  // so a disabled function never reacts to the other's traffic
  wire [35:0] nxt_gpio_i = host_mode ? {C_IN, D_IN[31:16], A_IN[19:16]}
                                     : 36'h000000000;
  wire [15:0] nxt_h_addr = host_mode ? A_IN[15:0] : 16'h0000;
  wire [15:0] nxt_h_data = host_mode ? D_IN[15:0] : 16'h0000;
  wire [31:0] nxt_m_data = mem_mode ? D_IN : 32'h00000000;
  wire [15:0] nxt_m_ctrl = mem_mode ? C_IN : 16'h0000;

  // Register value: mode bit 0, serial 2 mode bit 2
  wire [15:0] nxt_bsr = BSR_RESET_VALUE
                      | (16'(st.pmux_mode) << BSR_PMUX_BIT)
                      | (16'(st.ser2_mode) << BSR_SER2_BIT);

  ////////////////////////////////////////////////////////////////////
  // Address pads; enables off (high) throughout reset. One short
  // process per pad group keeps reset and next value side by side
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      A_OUT  <= 20'h00000;
      A_OE_N <= 20'hFFFFF;
    end else begin
      A_OUT  <= nxt_a_out;
      A_OE_N <= ~nxt_a_oe;
    end
  end

  // Data pads
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      D_OUT  <= 32'h00000000;
      D_OE_N <= 32'hFFFFFFFF;
    end else begin
      D_OUT  <= nxt_d_out;
      D_OE_N <= ~nxt_d_oe;
    end
  end

  // Control pads
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      C_OUT  <= 16'h0000;
      C_OE_N <= 16'hFFFF;
    end else begin
      C_OUT  <= nxt_c_out;
      C_OE_N <= ~nxt_c_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // General I/O pin levels
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      GPIO_I <= 36'h000000000;
    end else begin
      GPIO_I <= nxt_gpio_i;
    end
  end

  // Host port inputs
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_ADDR   <= 16'h0000;
      HOST_DATA_I <= 16'h0000;
    end else begin
      HOST_ADDR   <= nxt_h_addr;
      HOST_DATA_I <= nxt_h_data;
    end
  end

  // Memory interface inputs
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      MEM_DATA_I <= 32'h00000000;
      MEM_CTRL_I <= 16'h0000;
    end else begin
      MEM_DATA_I <= nxt_m_data;
      MEM_CTRL_I <= nxt_m_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Function enables; the memory interface is the only owner of the pads when enabled
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      MEM_ENABLE     <= 1'b0;
      HOST_BYTE_PINS <= 1'b0;
    end else begin
      MEM_ENABLE     <= mem_mode;
      HOST_BYTE_PINS <= mem_mode;
    end
  end

  // Wide host and general I/O travel together in strap-low mode
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_WIDE   <= 1'b0;
      GPIO_ENABLE <= 1'b0;
    end else begin
      HOST_WIDE   <= host_mode;
      GPIO_ENABLE <= host_mode;
    end
  end

  // Bus selection register, a read-only view with no write path
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUS_SEL_REG <= BSR_RESET_VALUE;
    end else begin
      BUS_SEL_REG <= nxt_bsr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Boot outputs
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BOOT_CODE   <= 3'h0;
      BOOT_SRC    <= 3'h0;
      BOOT_DIRECT <= 1'b0;
    end else begin
      BOOT_CODE   <= st.boot_code;
      BOOT_SRC    <= boot_src;
      BOOT_DIRECT <= boot_direct;
    end
  end

  // Capture flag, raised with the first valid mode on the outputs
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      STRAP_DONE <= 1'b0;
    end else begin
      STRAP_DONE <= st.done;
    end
  end

endmodule

// >>> logic/pmux_pkg.sv
/*
  Constants and types shared by the parallel port strap multiplexer.
  Assumes nothing beyond a SystemVerilog-aware tool flow.
*/
package pmux_pkg;

  // Pin group widths
  localparam int ADDR_W  = 20;               // Pins A[21:2]
  localparam int DATA_W  = 32;               // Pins D[31:0]
  localparam int CTRL_W  = 16;               // Pins C[15:0]
  localparam int HADDR_W = 16;               // Host address lines
  localparam int HDATA_W = 16;               // Host data lines
  localparam int GPIO_W  = 36;               // Parallel general I/O 35..0
  localparam int BOOT_W  = 3;                // Boot-mode straps

  // Field positions inside the parallel general I/O vector
  localparam int GPIO_ADDR_LO = 0;           // A[21:18] -> gpio[3:0]
  localparam int GPIO_DATA_LO = 4;           // D[31:16] -> gpio[19:4]
  localparam int GPIO_CTRL_LO = 20;          // C[15:0]  -> gpio[35:20]

  // Bus selection register
  localparam logic [15:0] BUS_SEL_ADDR    = 16'h6C00;
  localparam int          BSR_PMUX_BIT    = 0;
  localparam int          BSR_SER2_BIT    = 2;
  localparam logic [15:0] BSR_RESET_VALUE = 16'h0000;

  // Control pin positions in memory-interface mode
  localparam int C_RD_STB = 0;
  localparam int C_OE_STB = 1;
  localparam int C_WE_STB = 2;
  localparam int C_READY  = 3;
  localparam int C_CE_LO  = 4;
  localparam int C_BE_LO  = 8;
  localparam int C_SDCKE  = 12;
  localparam int C_SOE    = 13;
  localparam int C_HOLD   = 14;
  localparam int C_HOLDA  = 15;

  // Boot source decode
  typedef enum logic [2:0] {
    BOOT_DIRECT16 = 3'h0,
    BOOT_SPI_ROM  = 3'h1,
    BOOT_SERIAL   = 3'h2,
    BOOT_EXTMEM16 = 3'h3,
    BOOT_DIRECT32 = 3'h4,
    BOOT_HOST     = 3'h5,
    BOOT_I2C_ROM  = 3'h6,
    BOOT_UART     = 3'h7
  } boot_src_t;

  typedef enum logic {
    MODE_HOST16 = 1'b0,
    MODE_MEMIF  = 1'b1
  } pmux_mode_t;

endpackage

// >>> logic/strap_if.sv
/*
  Interface carrying the strap capture results between the strap
  latch and the multiplexer. Assumes one clock domain.
*/
`timescale 1ns/100ps
interface strap_if;
  import pmux_pkg::*;
  logic       pmux_mode;                     // 1 memory interface mode
  logic       ser2_mode;                     // Serial port 2 strap
  logic [2:0] boot_code;                     // Latched boot straps
  logic       done;                          // Straps valid
  modport latch (output pmux_mode, ser2_mode, boot_code, done);
  modport user  (input  pmux_mode, ser2_mode, boot_code, done);
endinterface

// >>> logic/strap_latch.sv
/*
  Captures strap pins at the release of reset.
  Assumes rst_n is the synchronised reset and straps are steady then.
*/
`timescale 1ns/100ps
module strap_latch
  import pmux_pkg::*;
(
  input  wire logic       clk,               // System clock
  input  wire logic       rst_n,             // Synchronised reset
  input  wire logic       pmux_strap,        // Parallel mux strap level
  input  wire logic       ser2_strap,        // Serial 2 mux strap level
  input  wire logic [2:0] boot_strap,        // Boot straps on gpio[2:0]
  strap_if.latch          st                 // Capture results
);

  logic       done_ff;
  logic       pmux_ff;
  logic       ser2_ff;
  logic [2:0] boot_ff;
  wire        take = !done_ff;              // Only first edge after release

  ////////////////////////////////////////////////////////////////////
  // Sample once at the first edge after release; async reset loads
  // constants only, so the strap is caught by a clocked load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      pmux_ff <= 1'b0;
      ser2_ff <= 1'b0;
      boot_ff <= 3'h0;
    end else if (take) begin
      done_ff <= 1'b1;
      pmux_ff <= pmux_strap;
      ser2_ff <= ser2_strap;
      boot_ff <= boot_strap;
    end
  end

  assign st.pmux_mode = pmux_ff;
  assign st.ser2_mode = ser2_ff;
  assign st.boot_code = boot_ff;
  assign st.done      = done_ff;

endmodule

// >>> logic/boot_decode.sv
/*
  Decodes the latched boot straps into a boot source and a flag that
  disables on-chip ROM for direct execution. Purely combinational.
*/
`timescale 1ns/100ps
module boot_decode
  import pmux_pkg::*;
(
  input  wire logic [2:0] code,              // Latched boot code
  output boot_src_t       src,               // Decoded boot source
  output logic            direct,            // Direct execution mode
  output logic            wide32             // 32-bit direct memory
);

  // Both direct codes bypass the loader, width differs
  assign src    = boot_src_t'(code);
  assign direct = (src == BOOT_DIRECT16) || (src == BOOT_DIRECT32);
  assign wide32 = (src == BOOT_DIRECT32);

endmodule

// >>> bench/pmux_properties.sv
/*
  Concurrent checks on the top ports of the parallel port strap mux.
  Assumes a single clock and the latency-one pin paths of the design.
*/
`timescale 1ns/100ps
module pmux_properties
  import pmux_pkg::*;
(
  input wire logic        SYS_CLK,       // Clock
  input wire logic        RESET_N,       // Reset, active low
  input wire logic [19:0] A_IN,          // Address pin levels
  input wire logic [19:0] A_OUT,         // Address pin values
  input wire logic [19:0] A_OE_N,        // Address enables
  input wire logic [31:0] D_IN,          // Data pin levels
  input wire logic [31:0] D_OE_N,        // Data enables
  input wire logic [19:0] MEM_ADDR,      // Memory address
  input wire logic        MEM_DATA_OE,   // Memory drives data
  input wire logic [31:0] MEM_DATA_I,    // Memory read data
  input wire logic        MEM_ENABLE,    // Memory mode
  input wire logic [15:0] HOST_ADDR,     // Host address lines
  input wire logic        HOST_DATA_OE,  // Host drives data
  input wire logic [35:0] GPIO_I,        // General I/O levels
  input wire logic        GPIO_ENABLE,   // General I/O mode
  input wire logic [15:0] BUS_SEL_REG,   // Bus selection register
  input wire logic [2:0]  BOOT_CODE,     // Latched boot code
  input wire logic [2:0]  BOOT_SRC,      // Boot source
  input wire logic        BOOT_DIRECT,   // Direct execution
  input wire logic        STRAP_DONE     // Straps captured
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // Two settled cycles so that $past never reaches into the capture
  sequence s_host;
    STRAP_DONE && $past(STRAP_DONE) && !BUS_SEL_REG[BSR_PMUX_BIT];
  endsequence
  sequence s_mem;
    STRAP_DONE && $past(STRAP_DONE) && BUS_SEL_REG[BSR_PMUX_BIT];
  endsequence
  sequence s_wait;
    !STRAP_DONE ##1 !STRAP_DONE ##[1:5] STRAP_DONE;
  endsequence

  a_host_addr_pins: assert property (s_host |->
    HOST_ADDR == $past(A_IN[15:0]) && &A_OE_N[15:0]) else $error("host addr");
  a_gpio_in_map: assert property (s_host |->
    GPIO_I[19:0] == $past({D_IN[31:16], A_IN[19:16]})) else $error("gpio in");
  a_host_data_oe: assert property (s_host |->
    D_OE_N[15:0] == {16{!$past(HOST_DATA_OE)}}) else $error("host oe");
  a_mem_addr_out: assert property (s_mem |->
    A_OE_N == 20'h0 && A_OUT == $past(MEM_ADDR)) else $error("mem addr");
  a_mem_data_path: assert property (s_mem |->
    MEM_DATA_I == $past(D_IN) && D_OE_N == {32{!$past(MEM_DATA_OE)}})
    else $error("mem data");
  a_owner_flags: assert property (STRAP_DONE |->
    MEM_ENABLE == BUS_SEL_REG[0] && GPIO_ENABLE != BUS_SEL_REG[0] &&
    BUS_SEL_REG[15:3] == 13'h0 && !BUS_SEL_REG[1]) else $error("owner");
  a_mode_held: assert property (STRAP_DONE && $past(STRAP_DONE) |->
    $stable(BUS_SEL_REG) && $stable(BOOT_CODE)) else $error("mode moved");
  a_boot_decode: assert property (STRAP_DONE |-> BOOT_SRC == BOOT_CODE &&
    BOOT_DIRECT == (BOOT_CODE[1:0] == 2'h0)) else $error("boot decode");
  a_release_order: assert property ($rose(RESET_N) |-> s_wait)
    else $error("strap capture late");
  a_quiet_pins: assert property (!STRAP_DONE |-> &A_OE_N && &D_OE_N)
    else $error("pins driven early");
endmodule

bind parallel_port_strap_mux pmux_properties u_pmux_properties (.*);

// >>> bench/pad_far_side.sv
/*
  Far side of the parallel pins: memory devices or an external host.
  Assumes the bench supplies what the far side drives on each pin.
*/
`timescale 1ns/100ps
module pad_far_side (
  input  wire logic [67:0] dev_out,    // Device pin values {C,D,A}
  input  wire logic [67:0] dev_oe_n,   // Device enables, low drives
  input  wire logic [67:0] far,        // Far side drive values
  output logic      [67:0] pin         // Resolved pin levels
);
  // Far side drives only where the device has released the pin
  assign pin = (dev_oe_n & far) | (~dev_oe_n & dev_out);
endmodule

// >>> bench/tb_top.sv
/*
  Self-checking bench for the parallel port strap mux.
  Assumes the far side pad model and the bound property checker.
*/
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, (exp), (got)); end end
module tb_top;
  import pmux_pkg::*;
  logic        SYS_CLK = 0, RESET_N = 0, PMUX_STRAP = 0, SER2_STRAP = 0;
  logic [2:0]  BOOT_STRAP = 3'h0, BOOT_CODE, BOOT_SRC;
  logic [19:0] A_IN, A_OUT, A_OE_N, MEM_ADDR = 20'h0;
  logic [31:0] D_IN, D_OUT, D_OE_N, MEM_DATA_O = 32'h0, MEM_DATA_I;
  logic [15:0] C_IN, C_OUT, C_OE_N, MEM_CTRL_O = 16'h0, MEM_CTRL_OE = 16'h0;
  logic [15:0] MEM_CTRL_I, HOST_ADDR, HOST_DATA_O = 16'h0, HOST_DATA_I;
  logic [15:0] BUS_SEL_REG;
  logic [35:0] GPIO_O = 36'h0, GPIO_DIR = 36'h0, GPIO_I;
  logic        MEM_DATA_OE = 0, HOST_DATA_OE = 0, MEM_ENABLE, HOST_WIDE;
  logic        HOST_BYTE_PINS, GPIO_ENABLE, BOOT_DIRECT, STRAP_DONE;
  logic [67:0] far = 68'h0;
  wire  [67:0] pins;
  int          n_errors = 0, n_checks = 0;

  parallel_port_strap_mux u_parallel_port_strap_mux (.*);
  pad_far_side u_pad_far_side (.dev_out({C_OUT, D_OUT, A_OUT}),
    .dev_oe_n({C_OE_N, D_OE_N, A_OE_N}), .far(far), .pin(pins));
  assign {C_IN, D_IN, A_IN} = pins;

  always #10 SYS_CLK = ~SYS_CLK;

  ////////////////////////////////////////////////////////////////////////////
  // Inputs always move 2 ns after a rising edge
  task automatic step(int n);
    repeat (n) @(posedge SYS_CLK);
    #2;
  endtask

  // Straps stay steady from release until capture is reported
  task automatic restart(logic pm, logic s2, logic [2:0] bm);
    int k;
    RESET_N = 1'h0;
    PMUX_STRAP = pm;                   // Set here while reset is held low
    SER2_STRAP = s2;
    BOOT_STRAP = bm;
    step(3);
    RESET_N = 1'h1;
    k = 0;
    while (STRAP_DONE !== 1'h1 && k < 20) begin
      step(1);
      k++;
    end
    `CHK("strap_done", 1'h1, STRAP_DONE)
  endtask

  // Every boot code, both modes; later strap changes must not stick
  task automatic boot_codes;
    for (int c = 0; c < 8; c++) begin
      restart(c[0], c[1], c[2:0]);
      `CHK("bsr", {13'h0, c[1], 1'h0, c[0]}, BUS_SEL_REG)
      `CHK("boot_code", c[2:0], BOOT_CODE)
      `CHK("boot_src", c[2:0], BOOT_SRC)
      `CHK("direct", c[1:0] == 2'h0, BOOT_DIRECT)
      `CHK("mem_en", c[0], MEM_ENABLE)
      `CHK("host_wide", ~c[0], HOST_WIDE)
      `CHK("byte_pins", c[0], HOST_BYTE_PINS)
      PMUX_STRAP = ~c[0];
      BOOT_STRAP = ~c[2:0];
      step(3);
      `CHK("held_mode", c[0], BUS_SEL_REG[0])
      `CHK("held_boot", c[2:0], BOOT_CODE)
    end
  endtask

  // Host mode: inputs, then general I/O and host driving the pins
  task automatic host_paths;
    restart(1'h0, 1'h0, 3'h5);
    far = 68'hA_5A5A_C3C3_9696_1234;
    step(2);
    `CHK("host_addr", far[15:0], HOST_ADDR)
    `CHK("host_data", far[35:20], HOST_DATA_I)
    `CHK("gpio_in", {far[67:36], far[19:16]}, GPIO_I)
    `CHK("addr_oe", 16'hFFFF, A_OE_N[15:0])
    `CHK("mem_quiet", 32'h0, MEM_DATA_I)
    GPIO_DIR = {36{1'h1}};
    GPIO_O = 36'h9_8765_4321;
    HOST_DATA_OE = 1'h1;
    HOST_DATA_O = 16'hBEEF;
    step(2);
    `CHK("gpio_oe", 36'h0, {C_OE_N, D_OE_N[31:16], A_OE_N[19:16]})
    `CHK("gpio_out", GPIO_O, {C_OUT, D_OUT[31:16], A_OUT[19:16]})
    `CHK("host_rd", 16'hBEEF, D_OUT[15:0])
    `CHK("gpio_loop", GPIO_O, GPIO_I)
    GPIO_DIR = 36'h0;
    HOST_DATA_OE = 1'h0;
  endtask

  // Memory mode: write, control split, then read back from the far side
  task automatic mem_paths;
    restart(1'h1, 1'h1, 3'h3);
    far = 68'h3_C0DE_1357_9BDF_2468;
    MEM_ADDR = 20'hABCDE;
    MEM_DATA_OE = 1'h1;
    MEM_DATA_O = 32'hCAFE_F00D;
    MEM_CTRL_OE = 16'h00FF;
    MEM_CTRL_O = 16'h5A3C;
    step(2);
    `CHK("mem_addr", {20'h0, 20'hABCDE}, {A_OE_N, A_OUT})
    `CHK("mem_wr", 32'hCAFE_F00D, D_OUT)
    `CHK("ctrl_oe", 16'hFF00, C_OE_N)
    `CHK("ctrl_in", {far[67:60], 8'h3C}, MEM_CTRL_I)
    `CHK("gpio_off", 36'h0, GPIO_I)
    MEM_DATA_OE = 1'h0;
    step(2);
    `CHK("mem_rd", far[51:20], MEM_DATA_I)
    `CHK("host_off", 16'h0, HOST_ADDR)
  endtask

  // Reset in mid-run releases every pin, then the other mode is taken
  task automatic mid_reset;
    RESET_N = 1'h0;
    step(1);
    `CHK("oe_reset", {68{1'h1}}, {A_OE_N, D_OE_N, C_OE_N})
    `CHK("done_reset", 1'h0, STRAP_DONE)
    restart(1'h0, 1'h0, 3'h0);
    `CHK("host_after", 1'h1, GPIO_ENABLE)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run is about 110 cycles; this limit is far beyond it
  initial begin
    #50000;
    n_errors++;
    close_out();
  end

  initial begin
    boot_codes();
    host_paths();
    mem_paths();
    mid_reset();
    close_out();
  end
endmodule
